// ===== verilog/vife_pkg.sv
// constants and carrier types of the video input front end
//
// Notes on behaviour
// - two-bit field picks format: 00 embedded sync, 01 8-bit, 10 16-bit
// - 8-bit format times capture from separate hsync, vsync, field pins
// - 16-bit format carries luma on Y and Cb/Cr on C together
// - embedded-sync stream comes from Y or C port by one select bit
// - 8-bit separate-sync format reads only Y, C port ignored
// - each sync input and the pixel clock has its own polarity
// - external field ID honoured only for interlaced input
// - without field ID, interlace found from vsync phase against hsync
// - interlaced input without field ID gets an internal field ID
// - idle hsync or vsync forces embedded-sync decoding
// - EAV/SAV codes decoded into internal hsync, vsync and field
// - any image size accepted when codes are present
// - pixels of the selected port are forwarded to the buffer side
// - separate one-bit polarity controls for hsync, vsync, field ID
// - read-only interlace detect bit and sync activity bit
// - hsync and vsync periods reported as 12-bit counts
// - interlaced frame built from two consecutive fields
package vife_pkg;
  localparam logic [1:0] FMT_BT656 = 2'h0;
  localparam logic [1:0] FMT_SEP8  = 2'h1;
  localparam logic [1:0] FMT_SEP16 = 2'h2;
  localparam logic [1:0] FMT_RST   = 2'h0;
  localparam logic       PORT_RST  = 1'h0;
  localparam logic       POL_RST   = 1'h1;
  localparam int PIN_W   = 21;
  localparam int PIN_Y   = 0;
  localparam int PIN_C   = 8;
  localparam int PIN_HS  = 16;
  localparam int PIN_VS  = 17;
  localparam int PIN_FID = 18;
  localparam int PIN_CLK = 20;
  // released pins: data and syncs pulled up, pixel clock pulled down
  localparam logic [PIN_W-1:0] PIN_RST = 21'h07_FFFF;
  localparam int CNT_W   = 12;
  localparam int TMO_W   = 23;
  localparam int XY_F    = 6;
  localparam int XY_V    = 5;
  localparam int XY_H    = 4;
  localparam logic [7:0]  CODE_FF       = 8'hFF;
  localparam logic [7:0]  CODE_00       = 8'h00;
  localparam logic [11:0] INTERLACE_TOL = 12'h004;
  localparam int FRAME_TIMEOUT_NS = 32'h0262_5A00;
  localparam int CLK_PERIOD_NS    = 32'h0000_000A;
  localparam logic [TMO_W-1:0] TIMEOUT_CYCLES =
    TMO_W'(FRAME_TIMEOUT_NS / CLK_PERIOD_NS);

  typedef struct packed {
    logic [1:0] inputFormatSelect;
    logic       embeddedSyncPortSelect;
    logic       hsyncPolarity;
    logic       vsyncPolarity;
    logic       fieldIdPolarity;
    logic       pixelClockPolarity;
  } vife_cfg_type;

  typedef struct packed {
    logic [CNT_W-1:0] hsyncPeriodCount;
    logic [CNT_W-1:0] vsyncPeriodCount;
    logic             interlaceDetectStatus;
    logic             syncActivityStatus;
  } vife_status_type;

  typedef struct packed {
    logic [7:0] luma;
    logic [7:0] chroma;
    logic       valid;
    logic       field;
    logic       lineStart;
    logic       frameStart;
  } vife_pixel_type;

  typedef enum logic [3:0] {
    DEC_SEEK = 4'h1,
    DEC_PRE1 = 4'h2,
    DEC_PRE2 = 4'h4,
    DEC_CODE = 4'h8
  } vife_dec_type;
endpackage

// ===== verilog/vife_front_end.sv
// video input front end: pin sampling, sync recovery, pixel hand-off
`timescale 1ns/1ns
module vife_front_end
#(
  parameter logic [vife_pkg::TMO_W-1:0] ACT_TIMEOUT =
    vife_pkg::TIMEOUT_CYCLES
)
(
  input  wire logic                   ref_clk,
  input  wire logic                   rst,
  input  wire logic                   clkEn,
  input  wire vife_pkg::vife_cfg_type cfg,
  input  wire logic                   videoPixelClock,
  input  wire logic [7:0]             lumaPort,
  input  wire logic [7:0]             chromaPort,
  input  wire logic                   videoHsyncIn,
  input  wire logic                   videoVsyncIn,
  input  wire logic                   fieldIdPin,
  output vife_pkg::vife_status_type   status,
  output vife_pkg::vife_pixel_type    pixelOut
);
  localparam int W = vife_pkg::PIN_W;
  localparam int N = vife_pkg::CNT_W;
  localparam int T = vife_pkg::TMO_W;

  // ****************************************
  // pin sampling, three sync stages and a filter stage
  // ****************************************
  logic [W-1:0] pinsIn;
  logic [W-1:0] meta1_r;
  logic [W-1:0] meta2_r;
  logic [W-1:0] meta3_r;
  logic [W-1:0] pinF_r;
  logic [W-1:0] pinF_nxt;

  assign pinsIn = {videoPixelClock, 1'b0, fieldIdPin, videoVsyncIn,
                   videoHsyncIn, chromaPort, lumaPort};

  always_comb
  begin
    pinF_nxt = (meta3_r & ~(meta2_r ^ meta3_r))
             | (pinF_r & (meta2_r ^ meta3_r));
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      // rest at pull levels so idle pins show no edge after reset
      meta1_r <= vife_pkg::PIN_RST;
      meta2_r <= vife_pkg::PIN_RST;
      meta3_r <= vife_pkg::PIN_RST;
      pinF_r  <= vife_pkg::PIN_RST;
    end
    else if (clkEn)
    begin
      meta1_r <= pinsIn;
      meta2_r <= meta1_r;
      meta3_r <= meta2_r;
      pinF_r  <= pinF_nxt;
    end
  end

  // ****************************************
  // polarity, edges, activity, measurement
  // ****************************************
  vife_pkg::vife_cfg_type cfg_r;
  logic [2:0]   syncPrev_r;
  logic [T-1:0] idle_r [3];
  logic [T-1:0] idle_nxt [3];
  logic         clkPrev_r, hsUsePrev_r, vsUsePrev_r;
  logic [N-1:0] hCount_r, vCount_r, hPeriod_r, vPeriod_r, prevPhase_r;
  logic [N-1:0] hCount_nxt, vCount_nxt, hPeriod_nxt, vPeriod_nxt;
  logic [N-1:0] prevPhase_nxt, phaseDiff, vsPhase;
  logic         prevF_r, interlace_r, fieldInt_r;
  logic         prevF_nxt, interlace_nxt, fieldInt_nxt;
  logic         hsAct, vsAct, fidAct, pixEdge, hsActive, vsActive;
  logic         fidActive, embedded, hsUse, vsUse, hsLead, vsLead;
  logic         fieldUsed, hEmb_r, vEmb_r, fEmb_r;
  logic [7:0]   streamByte;

  // polarity bit set means active high
  assign hsAct   = pinF_r[vife_pkg::PIN_HS] ~^ cfg_r.hsyncPolarity;
  assign vsAct   = pinF_r[vife_pkg::PIN_VS] ~^ cfg_r.vsyncPolarity;
  assign fidAct  = pinF_r[vife_pkg::PIN_FID] ~^ cfg_r.fieldIdPolarity;
  assign pixEdge = (pinF_r[vife_pkg::PIN_CLK] ~^ cfg_r.pixelClockPolarity)
                 & ~clkPrev_r;
  assign hsActive  = idle_r[0] < ACT_TIMEOUT;
  assign vsActive  = idle_r[1] < ACT_TIMEOUT;
  assign fidActive = idle_r[2] < ACT_TIMEOUT;
  // idle sync falls back to embedded codes
  assign embedded = (cfg_r.inputFormatSelect == vife_pkg::FMT_BT656)
                  | ~hsActive | ~vsActive;
  // separate pins time capture in 8/16-bit formats
  assign hsUse  = embedded ? hEmb_r : hsAct;
  assign vsUse  = embedded ? vEmb_r : vsAct;
  assign hsLead = hsUse & ~hsUsePrev_r;
  assign vsLead = vsUse & ~vsUsePrev_r;
  // port select: 0 = Y, 1 = C
  assign streamByte = cfg_r.embeddedSyncPortSelect
                    ? pinF_r[vife_pkg::PIN_C +: 8]
                    : pinF_r[vife_pkg::PIN_Y +: 8];
  // vsync phase within the line, zero when it meets an hsync lead
  assign vsPhase   = hsLead ? '0 : hCount_r;
  assign phaseDiff = (vsPhase > prevPhase_r) ? vsPhase - prevPhase_r
                                             : prevPhase_r - vsPhase;
  // external field ID when interlaced and active, internal when idle, 0 if progressive
  assign fieldUsed = embedded ? fEmb_r
                   : ~interlace_r ? 1'b0
                   : fidActive ? fidAct : fieldInt_r;

  always_comb
  begin
    hCount_nxt    = hCount_r;
    vCount_nxt    = vCount_r;
    hPeriod_nxt   = hPeriod_r;
    vPeriod_nxt   = vPeriod_r;
    prevPhase_nxt = prevPhase_r;
    prevF_nxt     = prevF_r;
    interlace_nxt = interlace_r;
    fieldInt_nxt  = fieldInt_r;
    for (int i = 0; i < 3; i++)
    begin
      // any edge on the filtered pin restarts its idle count
      if (pinF_r[vife_pkg::PIN_HS + i] != syncPrev_r[i])
        idle_nxt[i] = '0;
      else if (idle_r[i] < ACT_TIMEOUT)
        idle_nxt[i] = idle_r[i] + T'(1);
      else
        idle_nxt[i] = idle_r[i];
    end
    if (pixEdge && hCount_r != 12'hFFF)
      hCount_nxt = hCount_r + 12'h001;
    // period counts, pixels per line and lines per field
    if (hsLead)
    begin
      hPeriod_nxt = hCount_r;
      hCount_nxt  = '0;
      if (vCount_r != 12'hFFF)
        vCount_nxt = vCount_r + 12'h001;
    end
    if (vsLead)
    begin
      vPeriod_nxt   = vCount_r;
      // a coinciding hsync lead opens the first line of the new field
      vCount_nxt    = {{(N-1){1'b0}}, hsLead};
      prevPhase_nxt = vsPhase;
      prevF_nxt     = fEmb_r;
      // half-line vsync phase shift between fields means interlace
      interlace_nxt = embedded ? (fEmb_r != prevF_r)
                    : (fidActive | (phaseDiff > vife_pkg::INTERLACE_TOL));
      fieldInt_nxt  = vsPhase >= {1'b0, hPeriod_r[N-1:1]};
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      cfg_r <= '{vife_pkg::FMT_RST, vife_pkg::PORT_RST, vife_pkg::POL_RST,
                 vife_pkg::POL_RST, vife_pkg::POL_RST, vife_pkg::POL_RST};
      syncPrev_r  <= vife_pkg::PIN_RST[vife_pkg::PIN_HS +: 3];
      clkPrev_r   <= 1'b0;
      hsUsePrev_r <= 1'b0;
      vsUsePrev_r <= 1'b0;
      for (int i = 0; i < 3; i++)
        idle_r[i] <= ACT_TIMEOUT;
      hCount_r    <= '0;
      vCount_r    <= '0;
      hPeriod_r   <= '0;
      vPeriod_r   <= '0;
      prevPhase_r <= '0;
      prevF_r     <= 1'b0;
      interlace_r <= 1'b0;
      fieldInt_r  <= 1'b0;
    end
    else if (clkEn)
    begin
      cfg_r       <= cfg;
      syncPrev_r  <= pinF_r[vife_pkg::PIN_HS +: 3];
      clkPrev_r   <= pinF_r[vife_pkg::PIN_CLK] ~^ cfg_r.pixelClockPolarity;
      hsUsePrev_r <= hsUse;
      vsUsePrev_r <= vsUse;
      for (int i = 0; i < 3; i++)
        idle_r[i] <= idle_nxt[i];
      hCount_r    <= hCount_nxt;
      vCount_r    <= vCount_nxt;
      hPeriod_r   <= hPeriod_nxt;
      vPeriod_r   <= vPeriod_nxt;
      prevPhase_r <= prevPhase_nxt;
      prevF_r     <= prevF_nxt;
      interlace_r <= interlace_nxt;
      fieldInt_r  <= fieldInt_nxt;
    end
  end

  assign status = '{hPeriod_r, vPeriod_r, interlace_r,
                    hsActive & vsActive};

  // ****************************************
  // EAV/SAV decoder, size independent
  // ****************************************
  vife_pkg::vife_dec_type dec_r, dec_nxt;
  logic hEmb_nxt, vEmb_nxt, fEmb_nxt;

  always_comb
  begin
    dec_nxt  = dec_r;
    hEmb_nxt = hEmb_r;
    vEmb_nxt = vEmb_r;
    fEmb_nxt = fEmb_r;
    if (pixEdge && embedded)
    begin
      case (dec_r)
        vife_pkg::DEC_SEEK:
          dec_nxt = (streamByte == vife_pkg::CODE_FF) ? vife_pkg::DEC_PRE1
                                                      : vife_pkg::DEC_SEEK;
        vife_pkg::DEC_PRE1:
          dec_nxt = (streamByte == vife_pkg::CODE_00) ? vife_pkg::DEC_PRE2
                  : (streamByte == vife_pkg::CODE_FF) ? vife_pkg::DEC_PRE1
                  : vife_pkg::DEC_SEEK;
        vife_pkg::DEC_PRE2:
          dec_nxt = (streamByte == vife_pkg::CODE_00) ? vife_pkg::DEC_CODE
                                                      : vife_pkg::DEC_SEEK;
        vife_pkg::DEC_CODE:
        begin
          // code word fixes blanking and field state
          hEmb_nxt = streamByte[vife_pkg::XY_H];
          vEmb_nxt = streamByte[vife_pkg::XY_V];
          fEmb_nxt = streamByte[vife_pkg::XY_F];
          dec_nxt  = vife_pkg::DEC_SEEK;
        end
        default:
          dec_nxt = vife_pkg::DEC_SEEK;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      dec_r  <= vife_pkg::DEC_SEEK;
      hEmb_r <= 1'b1;
      vEmb_r <= 1'b1;
      fEmb_r <= 1'b0;
    end
    else if (clkEn)
    begin
      dec_r  <= dec_nxt;
      hEmb_r <= hEmb_nxt;
      vEmb_r <= vEmb_nxt;
      fEmb_r <= fEmb_nxt;
    end
  end

  // ****************************************
  // pixel hand-off to buffer controller
  // ****************************************
  vife_pkg::vife_pixel_type pix_nxt;
  logic framePend_r, framePend_nxt, linePend_r, linePend_nxt;
  logic pixValid;

  assign pixValid = embedded
    ? (dec_r == vife_pkg::DEC_SEEK && streamByte != vife_pkg::CODE_FF
       && !hEmb_r && !vEmb_r)
    : (!hsAct && !vsAct);

  always_comb
  begin
    pix_nxt            = pixelOut;
    pix_nxt.valid      = 1'b0;
    pix_nxt.lineStart  = 1'b0;
    pix_nxt.frameStart = 1'b0;
    framePend_nxt      = framePend_r | vsLead;
    linePend_nxt       = linePend_r | hsLead;
    if (pixEdge && pixValid)
    begin
      // embedded: selected port; 8-bit: Y only; 16-bit: Y and C
      pix_nxt.luma   = embedded ? streamByte : pinF_r[vife_pkg::PIN_Y +: 8];
      pix_nxt.chroma = (!embedded && cfg_r.inputFormatSelect ==
                        vife_pkg::FMT_SEP16)
                     ? pinF_r[vife_pkg::PIN_C +: 8] : 8'h00;
      pix_nxt.valid      = 1'b1;
      pix_nxt.field      = fieldUsed;
      pix_nxt.lineStart  = linePend_r;
      // a frame opens only with field 0; field 1 joins it
      pix_nxt.frameStart = framePend_r & ~fieldUsed;
      framePend_nxt      = vsLead;
      linePend_nxt       = hsLead;
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      pixelOut    <= '0;
      framePend_r <= 1'b0;
      linePend_r  <= 1'b0;
    end
    else if (clkEn)
    begin
      pixelOut    <= pix_nxt;
      framePend_r <= framePend_nxt;
      linePend_r  <= linePend_nxt;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  a_fmt_embedded: assert property (
    cfg_r.inputFormatSelect == vife_pkg::FMT_BT656 |-> embedded)
    else $error("embedded format not decoding codes");
  a_idle_embedded: assert property (
    (!hsActive || !vsActive) |-> embedded)
    else $error("idle sync without embedded fallback");
  a_idle_restart: assert property (
    clkEn && pinF_r[vife_pkg::PIN_HS] != syncPrev_r[0] |=> idle_r[0] == '0)
    else $error("hsync edge did not restart idle count");
  a_y_only: assert property (
    pixelOut.valid && !$past(embedded)
    && $past(cfg_r.inputFormatSelect) == vife_pkg::FMT_SEP8
    |-> pixelOut.chroma == 8'h00)
    else $error("chroma passed in 8-bit format");
  a_port_select: assert property (
    clkEn && pixEdge && pixValid && embedded
    |=> pixelOut.valid && pixelOut.luma == $past(
        cfg_r.embeddedSyncPortSelect ? pinF_r[vife_pkg::PIN_C +: 8]
                                     : pinF_r[vife_pkg::PIN_Y +: 8]))
    else $error("wrong port forwarded in embedded mode");
  a_hs_polarity: assert property (
    clkEn && pixEdge && !embedded
    && pinF_r[vife_pkg::PIN_HS] == cfg_r.hsyncPolarity |=> !pixelOut.valid)
    else $error("pixel taken during active hsync");
  a_hs_period: assert property (
    clkEn && hsLead |=> status.hsyncPeriodCount == $past(hCount_r))
    else $error("hsync period not captured");
  a_eav_decode: assert property (
    clkEn && pixEdge && embedded && dec_r == vife_pkg::DEC_CODE
    |=> hEmb_r == $past(streamByte[vife_pkg::XY_H])
        && vEmb_r == $past(streamByte[vife_pkg::XY_V]))
    else $error("code word not decoded");
  a_prog_field: assert property (
    !embedded && !interlace_r |-> !fieldUsed)
    else $error("field ID used on progressive input");
  a_frame_field: assert property (
    pixelOut.frameStart |-> pixelOut.valid && !pixelOut.field)
    else $error("frame opened on second field");

  c_embedded_pix: cover property (embedded && pixelOut.valid);
  c_sep16_pix: cover property (!embedded && pixelOut.valid
    && cfg_r.inputFormatSelect == vife_pkg::FMT_SEP16);
  c_interlace: cover property ($rose(interlace_r));
  c_frame: cover property (pixelOut.frameStart);
endmodule

// ===== verif/vife_video_source.sv
// behavioural camera source driving the video capture pins
`timescale 1ns/1ns
module vife_video_source
(
  output logic       videoPixelClock,
  output logic [7:0] lumaPort,
  output logic [7:0] chromaPort,
  output logic       videoHsyncIn,
  output logic       videoVsyncIn,
  output logic       fieldIdPin
);
  logic hPol;
  logic vPol;
  logic cPol;

  // released pins: data and syncs pulled up, clock pulled down
  task automatic idle();
    videoPixelClock = 1'h0;
    lumaPort        = 8'hFF;
    chromaPort      = 8'hFF;
    videoHsyncIn    = 1'h1;
    videoVsyncIn    = 1'h1;
    fieldIdPin      = 1'h1;
  endtask

  // one pixel period, data and syncs held across the active edge
  task automatic pix(
    input logic [7:0] y,
    input logic [7:0] c,
    input logic       h,
    input logic       v
  );
    videoPixelClock = ~cPol;
    lumaPort        = y;
    chromaPort      = c;
    videoHsyncIn    = h ~^ hPol;
    videoVsyncIn    = v ~^ vPol;
    #62;
    videoPixelClock = cPol;
    #63;
  endtask

  initial
  begin
    hPol = 1'h1;
    vPol = 1'h1;
    cPol = 1'h1;
    idle();
  end
endmodule

// ===== verif/test_video_input_front_end.sv
// self-checking bench for the video input front end
`timescale 1ns/1ns
module test_video_input_front_end;
  localparam logic [22:0] TMO = 23'h0_03E8;
  logic                      ref_clk;
  logic                      rst;
  logic                      clkEn;
  vife_pkg::vife_cfg_type    cfg;
  vife_pkg::vife_status_type status;
  vife_pkg::vife_pixel_type  pixelOut;
  logic                      pclk;
  logic [7:0]                yPin;
  logic [7:0]                cPin;
  logic                      hsPin;
  logic                      vsPin;
  logic                      fidPin;
  vife_pkg::vife_pixel_type  got[$];
  logic [7:0]                eY[$];
  logic [7:0]                eC[$];
  logic                      eF[$];
  int                        nFrame;
  int                        n_mismatch;
  int                        tests_run;
  int                        seq;

  vife_front_end #(.ACT_TIMEOUT(TMO)) uut
  (
    .ref_clk         (ref_clk),
    .rst             (rst),
    .clkEn           (clkEn),
    .cfg             (cfg),
    .videoPixelClock (pclk),
    .lumaPort        (yPin),
    .chromaPort      (cPin),
    .videoHsyncIn    (hsPin),
    .videoVsyncIn    (vsPin),
    .fieldIdPin      (fidPin),
    .status          (status),
    .pixelOut        (pixelOut)
  );

  vife_video_source src
  (
    .videoPixelClock (pclk),
    .lumaPort        (yPin),
    .chromaPort      (cPin),
    .videoHsyncIn    (hsPin),
    .videoVsyncIn    (vsPin),
    .fieldIdPin      (fidPin)
  );

  always #5 ref_clk = ~ref_clk;

  always @(posedge ref_clk)
    if (pixelOut.valid === 1'h1)
    begin
      got.push_back(pixelOut);
      if (pixelOut.frameStart === 1'h1)
        nFrame++;
    end

  task automatic complete_run();
    if (n_mismatch == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic flush();
    repeat (20) @(negedge ref_clk);
    got.delete();
    eY.delete();
    eC.delete();
    eF.delete();
    nFrame = 0;
  endtask

  task automatic setCfg(input logic [1:0] fmt, input logic port,
                        input logic pol);
    @(negedge ref_clk);
    cfg = '{fmt, port, pol, pol, 1'h1, pol};
    src.hPol = pol;
    src.vPol = pol;
    src.cPol = pol;
  endtask

  task automatic cmpPix(input bit ckC);
    repeat (20) @(negedge ref_clk);
    chk("pixel count", got.size(), eY.size());
    foreach (eY[i])
      if (i < got.size())
      begin
        chk("luma", got[i].luma, eY[i]);
        chk("field", got[i].field, eF[i]);
        if (ckC)
          chk("chroma", got[i].chroma, eC[i]);
      end
  endtask

  // embedded byte on the chosen port, syncs held still at their idle level
  task automatic emb(input logic [7:0] b);
    if (cfg.embeddedSyncPortSelect)
      src.pix(8'h55, b, 1'h1, 1'h1);
    else
      src.pix(b, 8'h55, 1'h1, 1'h1);
  endtask

  task automatic code(input logic [7:0] xy);
    emb(8'hFF);
    emb(8'h00);
    emb(8'h00);
    emb(xy);
  endtask

  task automatic embLine(input logic f, input logic v, input int n);
    logic [7:0] d;
    code({1'h1, f, v, 5'h00});
    for (int i = 0; i < n; i++)
    begin
      d = 8'(8'h10 + seq);
      seq++;
      emb(d);
      if (!v)
      begin
        eY.push_back(d);
        eC.push_back(8'h00);
        eF.push_back(f);
      end
    end
    code({1'h1, f, v, 5'h10});
    emb(8'h20);
    emb(8'h21);
  endtask

  task automatic embField(input logic f);
    embLine(f, 1'h1, 2);
    embLine(f, 1'h0, 4);
    embLine(f, 1'h0, 5);
  endtask

  // four lines of len clocks, hsync two clocks, vsync one line from vOff
  task automatic sepFrame(input bit keep, input int len, input int vOff,
                          input logic f);
    logic [7:0] d;
    logic       h;
    logic       v;
    for (int k = 0; k < 4 * len; k++)
    begin
      d = 8'(8'h40 + k);
      h = (k % len) < 2;
      v = k >= vOff && k < vOff + len;
      src.pix(d, ~d, h, v);
      if (keep && !h && !v)
      begin
        eY.push_back(d);
        eC.push_back(cfg.inputFormatSelect == vife_pkg::FMT_SEP8 ?
                     8'h00 : ~d);
        // pixels ahead of a late vsync still belong to the last field
        eF.push_back(k < vOff ? ~f : f);
      end
    end
  endtask

  task automatic sepPass();
    sepFrame(0, 8, 0, 1'h0);
    flush();
    sepFrame(1, 8, 0, 1'h0);
    sepFrame(1, 8, 0, 1'h0);
    cmpPix(1);
    chk("line period", status.hsyncPeriodCount, 12'h008);
    chk("frame period", status.vsyncPeriodCount, 12'h004);
    chk("activity", status.syncActivityStatus, 1'h1);
    chk("interlace", status.interlaceDetectStatus, 1'h0);
  endtask

  initial
  begin
    repeat (20000) @(posedge ref_clk);
    n_mismatch++;
    complete_run();
  end

  initial
  begin
    ref_clk = 1'h0;
    rst = 1'h1;
    clkEn = 1'h1;
    cfg = '{vife_pkg::FMT_BT656, 1'h0, 1'h1, 1'h1, 1'h1, 1'h1};
    n_mismatch = 0;
    tests_run = 0;
    seq = 0;
    nFrame = 0;
    repeat (10) @(negedge ref_clk);
    rst = 1'h0;
    chk("status after reset", status, '0);
    chk("pixel after reset", pixelOut, '0);
    embField(1'h0);
    embField(1'h1);
    embField(1'h0);
    cmpPix(0);
    chk("frame starts", nFrame, 2);
    chk("interlace", status.interlaceDetectStatus, 1'h1);
    // idle syncs keep embedded decoding despite the 8-bit setting
    setCfg(vife_pkg::FMT_SEP8, 1'h1, 1'h1);
    flush();
    embField(1'h0);
    cmpPix(0);
    setCfg(vife_pkg::FMT_SEP8, 1'h0, 1'h1);
    sepPass();
    setCfg(vife_pkg::FMT_SEP16, 1'h0, 1'h0);
    sepPass();
    // every other field has vsync half a line late, field pin idle
    sepFrame(0, 12, 0, 1'h0);
    sepFrame(0, 12, 6, 1'h1);
    flush();
    sepFrame(1, 12, 0, 1'h0);
    sepFrame(1, 12, 6, 1'h1);
    cmpPix(1);
    chk("sep interlace", status.interlaceDetectStatus, 1'h1);
    chk("long line", status.hsyncPeriodCount, 12'h00C);
    // clock enable low freezes the idle counters
    clkEn = 1'h0;
    src.idle();
    repeat (1100) @(negedge ref_clk);
    chk("frozen activity", status.syncActivityStatus, 1'h1);
    clkEn = 1'h1;
    repeat (1100) @(negedge ref_clk);
    chk("activity lost", status.syncActivityStatus, 1'h0);
    complete_run();
  end
endmodule
